// file: design/hmdc_core.sv
// Haptic drive control: duty measurement, source select, squelch, gain,
// low-pass filter and fault shutdown feeding an 8-bit converter code.
// Assumes the pulse-width pin and fault detectors are asynchronous to REF_CLK_I.
`timescale 1ns/1ns
`default_nettype none
module hmdc_core
  import hmdc_pkg::*;
(
  input  wire logic              REF_CLK_I,      // System clock, 250 MHz
  input  wire logic              SRST_I,         // Synchronous reset, active high
  input  wire hmdc_cfg_t         CFG_I,          // Configuration bits
  input  wire logic              PWM_IN_I,       // Pulse-width input pin
  input  wire logic              SHORT_DET_I,    // Overcurrent detector level
  input  wire logic              THERM_ALARM_I,  // Thermal alarm flag level
  output logic signed [7:0]      DAC_CODE_O,     // Signed converter code
  output logic                   MOUT_GND_O,     // Both motor outputs grounded
  output logic                   DRIVE_ACTIVE_O, // Drive path running
  output logic                   SHORT_FLAG_O    // Output short flag
);

  hmdc_state_t       state_r, state_nxt;
  logic              pwm_s1_r, pwm_s2_r, pwm_d_r;
  logic              sht_s1_r, sht_s2_r, thm_s1_r, thm_s2_r;
  logic [15:0]       hi_cnt_r, hi_cnt_nxt, per_cnt_r, per_cnt_nxt;
  logic              seen_r, seen_nxt;
  logic signed [7:0] code_r, code_nxt, duty_code, amp_c, target, env;
  logic [9:0]        sq_cnt_r, sq_cnt_nxt;
  logic signed [15:0] acc_r, acc_nxt, tgt_s;
  logic signed [16:0] diff, step;
  logic signed [7:0] dac_r, dac_nxt;
  logic              gnd_r, gnd_nxt, sht_r;
  logic              rise, fault, tick, squelched, in_sq;
  logic [31:0]       num, quo;
  logic signed [9:0] qc;
  logic [7:0]        mag;
  logic [3:0]        g1;
  logic signed [12:0] prod;
  logic [2:0]        shift;

  // Two-flop synchronisers; only the second stage is read
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      {pwm_s1_r, pwm_s2_r, pwm_d_r} <= 3'h0;
      {sht_s1_r, sht_s2_r, thm_s1_r, thm_s2_r} <= 4'h0;
    end else begin
      pwm_s1_r <= PWM_IN_I;
      pwm_s2_r <= pwm_s1_r;
      pwm_d_r  <= pwm_s2_r;
      sht_s1_r <= SHORT_DET_I;
      sht_s2_r <= sht_s1_r;
      thm_s1_r <= THERM_ALARM_I;
      thm_s2_r <= thm_s1_r;
    end
  end

  assign rise  = pwm_s2_r & ~pwm_d_r;
  assign fault = sht_s2_r | thm_s2_r;

  // Period and high-time counters, restarted at each rising edge
  always_comb begin
    per_cnt_nxt = (per_cnt_r == CNT_MAX) ? per_cnt_r : per_cnt_r + 16'h0001;
    hi_cnt_nxt  = (pwm_s2_r && hi_cnt_r != CNT_MAX) ? hi_cnt_r + 16'h0001 : hi_cnt_r;
    seen_nxt    = seen_r | rise;
    if (rise) begin
      per_cnt_nxt = 16'h0001;
      hi_cnt_nxt  = 16'h0001;
    end
  end

  // Rounded duty to code; the divider is wide but the clock has slack per period
  always_comb begin
    num = ({16'h0000, hi_cnt_r} * CODE_SPAN) + {17'h00000, per_cnt_r[15:1]};
    quo = (per_cnt_r == 16'h0000) ? 32'h0000_0000 : num / {16'h0000, per_cnt_r};
    qc  = (quo > CODE_SPAN) ? $signed(CODE_OFS) : $signed(quo[9:0]) - $signed(CODE_OFS);
    if (qc > $signed({2'h0, CODE_MAX})) begin
      duty_code = $signed(CODE_MAX);
    end else if (qc < -$signed({2'h0, CODE_MAX})) begin
      duty_code = -$signed(CODE_MAX);
    end else begin
      duty_code = qc[7:0];
    end
  end

  // Host amplitude of -128 is pulled in to keep the code symmetric
  assign amp_c = (CFG_I.host_drive_amplitude == 8'sh80) ? -$signed(CODE_MAX)
                                                        : CFG_I.host_drive_amplitude;

  // DC register mode samples every clock; otherwise once per pin period
  assign tick = (CFG_I.drive_source_select == SRC_REG &&
                 CFG_I.actuator_type_select != TYPE_LRA) ? 1'b1 : rise;

  always_comb begin
    code_nxt = code_r;
    if (CFG_I.drive_source_select == SRC_PWM) begin
      if (rise && seen_r) begin
        code_nxt = duty_code;
      end
    end else if (tick) begin
      code_nxt = amp_c;
    end
  end

  // Squelch counts ticks while the code sits inside the quiet band
  assign mag   = code_r[7] ? 8'(-code_r) : 8'(code_r);
  assign in_sq = mag <= {1'b0, CFG_I.drive_squelch_range};
  always_comb begin
    sq_cnt_nxt = sq_cnt_r;
    if (!in_sq) begin
      sq_cnt_nxt = 10'h000;
    end else if (tick && sq_cnt_r <= SQL_LIMIT) begin
      sq_cnt_nxt = sq_cnt_r + 10'h001;
    end
  end
  // Leaving the band lifts squelch at once, so a count left at 513 cannot mute a new level
  assign squelched = in_sq && (sq_cnt_r > SQL_LIMIT);

  // Gain as (setting+1)/8 keeps the full-scale result inside 127
  assign g1     = {1'b0, CFG_I.output_gain_setting} + 4'h1;
  assign prod   = code_r * $signed({1'b0, g1});
  assign target = squelched ? 8'sh00 : prod[10:3];

  // First-order low-pass; a larger bandwidth setting means a smaller shift
  assign tgt_s = {target, 8'h00};
  assign shift = BW_SHIFT_MAX - {1'b0, CFG_I.drive_filter_bandwidth};
  assign diff  = 17'(tgt_s) - 17'(acc_r);
  assign step  = diff >>> shift;
  always_comb begin
    acc_nxt = (state_r == ST_RUN) ? 16'(acc_r + step[15:0]) : ACC_RST;
  end
  assign env = acc_r[15:8];

  // Drive mode and fault handling; a cleared type field overrides faults
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (CFG_I.actuator_type_select != TYPE_OFF) begin
          state_nxt = fault ? ST_HALT : ST_RUN;
        end
      end
      ST_RUN: begin
        if (CFG_I.actuator_type_select == TYPE_OFF) begin
          state_nxt = ST_OFF;
        end else if (fault) begin
          state_nxt = ST_HALT;
        end
      end
      ST_HALT: begin
        if (CFG_I.actuator_type_select == TYPE_OFF) begin
          state_nxt = ST_OFF;
        end else if (!fault) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_OFF;
    endcase
  end

  // Converter code: DC level or envelope flipped by the pin for the carrier
  always_comb begin
    dac_nxt = DAC_RST;
    gnd_nxt = 1'b1;
    if (state_r == ST_RUN) begin
      gnd_nxt = 1'b0;
      if (CFG_I.actuator_type_select == TYPE_LRA) begin
        dac_nxt = pwm_s2_r ? env : 8'(-env);
      end else begin
        dac_nxt = env;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      state_r   <= ST_OFF;
      hi_cnt_r  <= 16'h0000;
      per_cnt_r <= 16'h0000;
      seen_r    <= 1'b0;
      code_r    <= 8'sh00;
      sq_cnt_r  <= 10'h000;
      acc_r     <= ACC_RST;
      dac_r     <= DAC_RST;
      gnd_r     <= 1'b1;
      sht_r     <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      hi_cnt_r  <= hi_cnt_nxt;
      per_cnt_r <= per_cnt_nxt;
      seen_r    <= seen_nxt;
      code_r    <= code_nxt;
      sq_cnt_r  <= sq_cnt_nxt;
      acc_r     <= acc_nxt;
      dac_r     <= dac_nxt;
      gnd_r     <= gnd_nxt;
      sht_r     <= sht_s2_r;
    end
  end

  assign DAC_CODE_O     = dac_r;
  assign MOUT_GND_O     = gnd_r;
  assign DRIVE_ACTIVE_O = state_r == ST_RUN;
  assign SHORT_FLAG_O   = sht_r;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);

  property p_type_off;
    CFG_I.actuator_type_select == TYPE_OFF |=> state_r == ST_OFF ##1 DAC_CODE_O == 8'sh00;
  endproperty
  a_type_off: assert property (p_type_off) else $error("drive not off");

  property p_erm_level;
    state_r == ST_RUN && CFG_I.actuator_type_select == TYPE_ERM |=> DAC_CODE_O == $past(env);
  endproperty
  a_erm_level: assert property (p_erm_level) else $error("dc level wrong");

  property p_lra_carrier;
    state_r == ST_RUN && CFG_I.actuator_type_select == TYPE_LRA && !pwm_s2_r
      |=> DAC_CODE_O == 8'(-$past(env));
  endproperty
  a_lra_carrier: assert property (p_lra_carrier) else $error("carrier phase wrong");

  property p_pwm_src;
    CFG_I.drive_source_select == SRC_PWM && rise && seen_r |=> code_r == $past(duty_code);
  endproperty
  a_pwm_src: assert property (p_pwm_src) else $error("pin code not taken");

  property p_reg_src;
    CFG_I.drive_source_select == SRC_REG && tick |=> code_r == $past(amp_c);
  endproperty
  a_reg_src: assert property (p_reg_src) else $error("host code not taken");

  property p_half_duty;
    per_cnt_r == 16'h00C8 && hi_cnt_r == 16'h0064 |-> duty_code == 8'sh00;
  endproperty
  a_half_duty: assert property (p_half_duty) else $error("half duty not zero");

  property p_squelch;
    sq_cnt_r > SQL_LIMIT && in_sq |-> target == 8'sh00;
  endproperty
  a_squelch: assert property (p_squelch) else $error("squelch not applied");

  property p_clamp;
    duty_code <= $signed(CODE_MAX) && duty_code >= -$signed(CODE_MAX);
  endproperty
  a_clamp: assert property (p_clamp) else $error("duty code out of range");

  property p_filter;
    state_r == ST_RUN && state_nxt == ST_RUN && diff >= 17'sh00100
      |=> acc_r > $past(acc_r);
  endproperty
  a_filter: assert property (p_filter) else $error("filter not moving");

  property p_short;
    sht_s2_r |=> SHORT_FLAG_O ##1 (MOUT_GND_O && DAC_CODE_O == 8'sh00);
  endproperty
  a_short: assert property (p_short) else $error("short not grounded");

  property p_therm_resume;
    state_r == ST_HALT && !fault && CFG_I.actuator_type_select != TYPE_OFF
      |=> state_r == ST_RUN;
  endproperty
  a_therm_resume: assert property (p_therm_resume) else $error("no resume");

  c_squelch: cover property (state_r == ST_RUN && squelched);
  c_halt:    cover property (state_r == ST_RUN ##1 state_r == ST_HALT);
  c_lra:     cover property (state_r == ST_RUN && CFG_I.actuator_type_select == TYPE_LRA && rise);
  c_erm_reg: cover property (state_r == ST_RUN && CFG_I.drive_source_select == SRC_REG
                             && CFG_I.actuator_type_select == TYPE_ERM);

endmodule : hmdc_core
`default_nettype wire

// file: design/hmdc_pkg.sv
// Constants, state codes and the configuration carrier for the haptic drive control.
// Assumes one synchronous clock domain; pin-side inputs are synchronised in the core.
// Contract
// - Drive path runs only while the actuator type field is nonzero.
// - Type 10 drives a DC motor; the level sign sets the direction.
// - Type 01 drives an alternating carrier whose envelope follows the level.
// - Source bit 0 takes the level from the pulse-width input.
// - Source bit 1 takes the level from the host signed amplitude.
// - Duty cycle gives a signed code per period; 50% maps to 0, extremes to 127.
// - Code inside squelch range for over 512 ticks forces zero output.
// - Output scales as code over 127 times the gain setting; the code scales the code by (setting+1)/8 instead.
// - Resonant envelope uses the same scaled code from the selected source.
// - Resonant register mode: pin sets carrier, amplitude sampled per pin period.
// - Code is low-pass filtered by bandwidth setting, then sent to 8-bit converter.
// - Overcurrent sets short flag, grounds both outputs, resumes when gone.
// - Thermal alarm stops driving; driving resumes at once when it clears.
package hmdc_pkg;

  localparam int unsigned   CNT_W        = 16;       // Period counter width
  localparam logic [15:0]   CNT_MAX      = 16'hFFFF; // Counter saturation value
  localparam logic [31:0]   CODE_SPAN    = 32'h0000_00FE; // 254 steps over full duty
  localparam logic [9:0]    CODE_OFS     = 10'h07F;  // Code offset 127
  localparam logic [7:0]    CODE_MAX     = 8'h7F;    // Largest magnitude 127
  localparam logic [9:0]    SQL_LIMIT    = 10'h200;  // Squelch tick limit 512
  localparam logic [2:0]    BW_SHIFT_MAX = 3'h4;     // Filter shift at lowest bandwidth
  localparam logic [15:0]   ACC_RST      = 16'h0000; // Filter reset value
  localparam logic [7:0]    DAC_RST      = 8'h00;    // Converter code after reset
  localparam logic [1:0]    TYPE_OFF     = 2'h0;     // Drive disabled
  localparam logic [1:0]    TYPE_LRA     = 2'h1;     // Resonant actuator
  localparam logic [1:0]    TYPE_ERM     = 2'h2;     // Rotating mass motor
  localparam logic          SRC_PWM      = 1'b0;     // Level from pulse-width pin
  localparam logic          SRC_REG      = 1'b1;     // Level from host amplitude

  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_RUN  = 3'b010,
    ST_HALT = 3'b100
  } hmdc_state_t;

  typedef struct packed {
    logic [1:0]        actuator_type_select;   // 00 off, 01 resonant, 10 DC motor
    logic              drive_source_select;    // 0 pin, 1 host amplitude
    logic [6:0]        drive_squelch_range;    // Magnitude treated as silence
    logic signed [7:0] host_drive_amplitude;   // Signed host level
    logic              drive_range_bit;        // Host sets 1 in DC register mode
    logic [2:0]        output_gain_setting;    // Gain is (setting+1)/8
    logic [1:0]        drive_filter_bandwidth; // Larger is faster
  } hmdc_cfg_t;

endpackage : hmdc_pkg

// file: verif/hmdc_core_tb_top.sv
// Self-checking bench for hmdc_core: integer model of duty code, gain and faults.
// Assumes one 250 MHz clock; the pin comes from hmdc_host_pwm.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s expected %0d seen %0d", nm, e, g); end end
module hmdc_core_tb_top;
  import hmdc_pkg::*;
  logic              ref_clk = 1'b0;
  logic              srst = 1'b1;
  logic              short_det = 1'b0;
  logic              therm = 1'b0;
  logic              pwm_en = 1'b0;
  logic [15:0]       hi_c = 16'h0064;
  logic [15:0]       per_c = 16'h00C8;
  hmdc_cfg_t         cfg = '0;
  logic              pin, gnd, act, sflag;
  logic signed [7:0] dac;
  int                n_mismatch = 0;
  int                checked = 0;

  always #2 ref_clk = ~ref_clk;

  hmdc_host_pwm i_host (.clk_i(ref_clk), .en_i(pwm_en), .high_i(hi_c), .per_i(per_c),
    .pin_o(pin));
  hmdc_core i_dut (.REF_CLK_I(ref_clk), .SRST_I(srst), .CFG_I(cfg), .PWM_IN_I(pin),
    .SHORT_DET_I(short_det), .THERM_ALARM_I(therm), .DAC_CODE_O(dac), .MOUT_GND_O(gnd),
    .DRIVE_ACTIVE_O(act), .SHORT_FLAG_O(sflag));

  task automatic end_of_test();
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  // Duty model: rounded linear map around mid scale, clamped
  function automatic int duty_code(input int h, input int p);
    int c;
    c = (2 * h * 254 + p) / (2 * p) - 127;
    return c > 127 ? 127 : c;
  endfunction : duty_code

  // Gain model, floor division by eight
  function automatic int tgt(input int code, input int g);
    return (code * (g + 1)) >>> 3;
  endfunction : tgt

  // The filter may stall one step short of its target, so one count is tolerated
  function automatic logic signed [7:0] near(input int e, input logic signed [7:0] g);
    return (g - e <= 1 && e - g <= 1) ? 8'(e) : g;
  endfunction : near

  task automatic look(input string nm, input int e);
    @(negedge ref_clk);
    `CHK(nm, 8'(e), near(e, dac))
  endtask : look

  task automatic setc(input logic [1:0] ty, input logic src, input int amp,
                      input int g, input logic [1:0] bw, input logic [6:0] sq);
    @(posedge ref_clk);
    cfg <= '{ty, src, sq, 8'(amp), src, 3'(g), bw};
  endtask : setc

  // Bounded wait on the run indication; running out ends the test
  task automatic wait_act(input logic v);
    for (int i = 0; i < 20 && act !== v; i++) @(negedge ref_clk);
    `CHK("active", v, act)
    if (act !== v) end_of_test();
  endtask : wait_act

  // Envelope sign follows the pin: sample mid high phase, then mid low phase
  task automatic lra_chk(input int e, input int h, input int p);
    int i;
    i = 0;
    while (pin !== 1'b0 && i < 1000) begin
      @(posedge ref_clk);
      i++;
    end
    while (pin !== 1'b1 && i < 1000) begin
      @(posedge ref_clk);
      i++;
    end
    if (i >= 1000) begin
      n_mismatch++;
      end_of_test();
    end
    cyc(h / 2);
    look("lra_pos", e);
    cyc(h / 2 + (p - h) / 2);
    look("lra_neg", -e);
  endtask : lra_chk

  initial begin
    int h, p, a, g;
    int duty[$];
    duty = '{100, 200, 126, 250, 124, 250, 1, 300, 299, 300};
    void'($urandom(32'h087c));
    cyc(1);
    @(negedge ref_clk);
    `CHK("rst_gnd", 1'b1, gnd)
    @(posedge ref_clk);
    srst <= 1'b0;
    cyc(6);
    look("off_dac", 0);
    `CHK("off_gnd", 1'b1, gnd)
    `CHK("off_act", 1'b0, act)
    `CHK("rst_flag", 1'b0, sflag)
    // Pin mode, DC motor: listed duties plus random ones; host amplitude ignored
    pwm_en <= 1'b1;
    repeat (3) duty.push_back(1 + $urandom_range(300));
    for (int i = 0; i < duty.size() / 2 + 1; i++) begin
      p = (i < 5) ? duty[2 * i + 1] : 60 + $urandom_range(200);
      h = (i < 5) ? duty[2 * i] : 1 + $urandom_range(p - 2);
      g = $urandom_range(7);
      setc(2'h2, SRC_PWM, 8'sh55, g, 2'h3, 7'h00);
      hi_c <= 16'(h);
      per_c <= 16'(p);
      cyc(3 * p + 30);
      look("dc_pin", tgt(duty_code(h, p), g));
    end
    // Host mode, DC motor, every gain; pin grounded by the host
    pwm_en <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? -128 : $urandom_range(255) - 128;
      setc(2'h2, SRC_REG, a, i, 2'h3, 7'h00);
      cyc(30);
      look("dc_host", tgt(a < -127 ? -127 : a, i));
    end
    // Small code inside the squelch band is silenced only after 512 ticks
    setc(2'h2, SRC_REG, 3, 7, 2'h3, 7'h05);
    cyc(300);
    look("sq_early", 3);
    cyc(300);
    look("sq_late", 0);
    // Slowest bandwidth: a step must not reach the converter at once
    setc(2'h2, SRC_REG, 100, 7, 2'h0, 7'h00);
    cyc(8);
    @(negedge ref_clk);
    `CHK("slew", 1'b1, dac > 8'sh00 && dac < 8'sh64)
    cyc(250);
    look("bw_settle", 100);
    // Resonant load, pin mode and host mode with pin carrier
    pwm_en <= 1'b1;
    setc(2'h1, SRC_PWM, 8'sh10, 7, 2'h3, 7'h00);
    hi_c <= 16'h0096;
    per_c <= 16'h00C8;
    cyc(650);
    lra_chk(duty_code(150, 200), 150, 200);
    setc(2'h1, SRC_REG, -40, 3, 2'h3, 7'h00);
    hi_c <= 16'h0064;
    cyc(650);
    lra_chk(tgt(-40, 3), 100, 200);
    // Short then thermal alarm: halt, ground, resume unaided
    pwm_en <= 1'b0;
    setc(2'h2, SRC_REG, 60, 7, 2'h3, 7'h00);
    cyc(30);
    for (int f = 0; f < 2; f++) begin
      @(posedge ref_clk);
      if (f == 0) short_det <= 1'b1;
      else therm <= 1'b1;
      wait_act(1'b0);
      cyc(2);
      @(negedge ref_clk);
      `CHK("short_flag", f == 0, sflag)
      `CHK("halt_gnd", 1'b1, gnd)
      look("halt_dac", 0);
      @(posedge ref_clk);
      short_det <= 1'b0;
      therm <= 1'b0;
      wait_act(1'b1);
      cyc(30);
      look("resume", 60);
      `CHK("flag_clear", 1'b0, sflag)
      `CHK("drive_gnd", 1'b0, gnd)
    end
    // Clearing the type field stops the path mid-run
    setc(2'h0, SRC_REG, 60, 7, 2'h3, 7'h00);
    wait_act(1'b0);
    cyc(3);
    look("stop_dac", 0);
    `CHK("stop_gnd", 1'b1, gnd)
    end_of_test();
  end

  // Watchdog against a hang anywhere in the sequence
  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
endmodule : hmdc_core_tb_top
`default_nettype wire

// file: verif/hmdc_host_pwm.sv
// Host-side model: the pulse-width source that feeds the drive pin.
// Assumes the bench clock; the pin moves only just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module hmdc_host_pwm (
  input  wire logic        clk_i,         // Bench clock
  input  wire logic        en_i,          // Low holds the pin grounded
  input  wire logic [15:0] high_i,        // High cycles per period
  input  wire logic [15:0] per_i,         // Period in cycles
  output var  logic        pin_o = 1'b0   // Pulse-width pin
);
  logic [15:0] cnt_r = 16'h0000;

  // Free-running period counter; grounding the pin keeps DC register mode quiet
  always @(posedge clk_i) begin
    cnt_r <= (cnt_r + 16'h0001 >= per_i) ? 16'h0000 : cnt_r + 16'h0001;
    pin_o <= en_i && (cnt_r < high_i);
  end
endmodule : hmdc_host_pwm
`default_nettype wire
